// File: rtl/lsgp_top.v
// Two GPIO ports, the first shared with the LCD, with a classic Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
`include "lsgp_defs.vh"
module lsgp_top (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// LCD controller
	input wire [3:0] segment_select_field_i,
	input wire [7:0] lcd_segment_output_i,
	// First port pins
	input wire [7:0] p1_pin_i,
	output wire [7:0] p1_pin_o,
	output wire [7:0] p1_pin_oe_o,
	output wire [7:0] p1_pullup_o,
	// Second port pins
	input wire [7:0] p2_pin_i,
	output wire [7:0] p2_pin_o,
	output wire [7:0] p2_pin_oe_o
);
	////////////////////////////////////////////////////////////////
	reg [7:0] first_port_data_reg_ff;
	reg [7:0] first_port_dir_reg_ff;
	reg [7:0] first_port_pullup_reg_ff;
	reg [7:0] second_port_data_reg_ff;
	reg [7:0] second_port_dir_reg_ff;
	reg ack_ff;
	reg [31:0] dat_ff;
	reg [7:0] p1_out_ff;
	reg [7:0] p1_oe_ff;
	reg [7:0] p1_pu_ff;
	reg [7:0] p2_out_ff;
	reg [7:0] p2_oe_ff;
	reg [3:0] seg_sel_ff;
	reg [7:0] nxt_p1_out;
	reg [7:0] nxt_p1_oe;
	reg [7:0] nxt_p1_pu;
	reg [7:0] nxt_rdata;
	wire [7:0] p1_sync;
	wire [7:0] p2_sync;
	wire seg_hi;
	wire seg_lo;
	wire [7:0] seg_mask;
	wire req;
	wire wr_lane0;
	wire [3:0] reg_idx;
	////////////////////////////////////////////////////////////////
	// Pin levels come from outside the clock domain
	lsgp_sync #(.WIDTH(8)) u_sync_p1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(p1_pin_i),
		.sync_o(p1_sync)
	);
	lsgp_sync #(.WIDTH(8)) u_sync_p2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(p2_pin_i),
		.sync_o(p2_sync)
	);
	////////////////////////////////////////////////////////////////
	// Bus decode; word addressing, registers sit in byte lane 0
	assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
	assign reg_idx = wb_adr_i[5:2];
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			first_port_data_reg_ff <= `LSGP_RST_BYTE;
			first_port_dir_reg_ff <= `LSGP_RST_BYTE;
			first_port_pullup_reg_ff <= `LSGP_RST_BYTE;
			second_port_data_reg_ff <= `LSGP_RST_BYTE;
			second_port_dir_reg_ff <= `LSGP_RST_BYTE;
		end
		else if (wr_lane0)
		begin
			case (reg_idx)
				`LSGP_ADR_P1_DATA: first_port_data_reg_ff <= wb_dat_i[7:0];
				`LSGP_ADR_P1_DIR: first_port_dir_reg_ff <= wb_dat_i[7:0];
				`LSGP_ADR_P1_PULL: first_port_pullup_reg_ff <= wb_dat_i[7:0];
				`LSGP_ADR_P2_DATA: second_port_data_reg_ff <= wb_dat_i[7:0];
				`LSGP_ADR_P2_DIR: second_port_dir_reg_ff <= wb_dat_i[7:0];
				default:
				begin
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets read zero and still ack
	always @*
	begin
		case (reg_idx)
			`LSGP_ADR_P1_DATA:
				nxt_rdata = (first_port_dir_reg_ff & first_port_data_reg_ff)
					| (~first_port_dir_reg_ff & p1_sync);
			`LSGP_ADR_P1_DIR: nxt_rdata = `LSGP_WO_READ;
			`LSGP_ADR_P1_PULL: nxt_rdata = first_port_pullup_reg_ff;
			`LSGP_ADR_P2_DATA:
				nxt_rdata = (second_port_dir_reg_ff & second_port_data_reg_ff)
					| (~second_port_dir_reg_ff & p2_sync);
			`LSGP_ADR_P2_DIR: nxt_rdata = `LSGP_WO_READ;
			default: nxt_rdata = 8'h00;
		endcase
	end
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
		end
		else
		begin
			ack_ff <= req;
			if (req & ~wb_we_i)
				dat_ff <= {24'h000000, nxt_rdata};
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	////////////////////////////////////////////////////////////////
	// Segment select is sampled once so every pin switches together
	always @(posedge clk_i)
	begin
		if (rst_i)
			seg_sel_ff <= 4'h0;
		else
			seg_sel_ff <= segment_select_field_i;
	end
	assign seg_hi = (seg_sel_ff >= `LSGP_HI_SEG_MIN)
		&& (seg_sel_ff <= `LSGP_HI_SEG_MAX);
	assign seg_lo = (seg_sel_ff >= `LSGP_LO_SEG_MIN)
		&& (seg_sel_ff <= `LSGP_LO_SEG_MAX);
	assign seg_mask = {{4{seg_hi}}, {4{seg_lo}}};
	////////////////////////////////////////////////////////////////
	// Pin muxing; pull-ups stay off on segment pins as they are driven
	always @*
	begin
		nxt_p1_out = (seg_mask & lcd_segment_output_i)
			| (~seg_mask & first_port_data_reg_ff);
		nxt_p1_oe = seg_mask | first_port_dir_reg_ff;
		nxt_p1_pu = ~seg_mask & ~first_port_dir_reg_ff
			& first_port_pullup_reg_ff;
	end
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			p1_out_ff <= 8'h00;
			p1_oe_ff <= 8'h00;
			p1_pu_ff <= 8'h00;
			p2_out_ff <= 8'h00;
			p2_oe_ff <= 8'h00;
		end
		else
		begin
			p1_out_ff <= nxt_p1_out;
			p1_oe_ff <= nxt_p1_oe;
			p1_pu_ff <= nxt_p1_pu;
			p2_out_ff <= second_port_data_reg_ff;
			p2_oe_ff <= second_port_dir_reg_ff;
		end
	end
	assign p1_pin_o = p1_out_ff;
	assign p1_pin_oe_o = p1_oe_ff;
	assign p1_pullup_o = p1_pu_ff;
	assign p2_pin_o = p2_out_ff;
	assign p2_pin_oe_o = p2_oe_ff;
endmodule
`default_nettype wire

// File: inc/lsgp_defs.vh
// Register map, reset values, segment select ranges and functional notes
// Functional notes
// - The first port has an eight-bit read/write data register that clears to zero on reset.
// - A read of the first port data returns the stored latch bit wherever the direction bit is one.
// - A read of the first port data returns the synchronised pin level wherever the direction bit is zero.
// - A first port direction bit of one makes the pin an output and zero an input, all clearing to zero.
// - The first port direction register is write-only and every bit reads back as one.
// - Direction and data settings act on a pin only while it is in general I/O use.
// - A pull-up is on only when the direction bit is zero and the pull-up enable bit is one.
// - The pull-up enable register is eight bits, read/write, and clears to zero on reset.
// - Upper four first port pins become segment outputs (index plus 9) for select values 0100 to 1011.
// - Lower four first port pins become segment outputs (index plus 9) for select values 0011 to 1010.
// - The second port data register clears to zero and reads latch bits for outputs, pin levels for inputs.
// - The second port direction register is write-only, makes outputs with ones, clears to zero, reads all ones.
`ifndef LSGP_DEFS_VH
`define LSGP_DEFS_VH
`define LSGP_ADR_P1_DATA 4'h0
`define LSGP_ADR_P1_DIR 4'h1
`define LSGP_ADR_P1_PULL 4'h2
`define LSGP_ADR_P2_DATA 4'h3
`define LSGP_ADR_P2_DIR 4'h4
`define LSGP_RST_BYTE 8'h00
`define LSGP_WO_READ 8'hFF
`define LSGP_HI_SEG_MIN 4'h4
`define LSGP_HI_SEG_MAX 4'hB
`define LSGP_LO_SEG_MIN 4'h3
`define LSGP_LO_SEG_MAX 4'hA
`endif

// File: rtl/lsgp_sync.v
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module lsgp_sync #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Data
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	// First stage feeds only the second stage
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end
	assign sync_o = sync_ff;
endmodule
`default_nettype wire

// File: bench/lsgp_properties.sv
// Checker: port-level behaviour of the shared GPIO ports
`timescale 1ns/100ps
`default_nettype none
module lsgp_checker (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// LCD select and pins
	input wire logic [3:0] segment_select_field_i,
	input wire logic [7:0] lcd_segment_output_i,
	input wire logic [7:0] p1_pin_o,
	input wire logic [7:0] p1_pin_oe_o,
	input wire logic [7:0] p1_pullup_o,
	input wire logic [7:0] p2_pin_oe_o
);
	logic tk, rd, wr, hi, lo;
	logic [3:0] s, ix;
	assign s = segment_select_field_i;
	assign ix = wb_adr_i[5:2];
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = tk && !wb_we_i;
	assign wr = tk && wb_we_i && wb_sel_i[0];
	assign hi = s >= 4'h4 && s <= 4'hB;
	assign lo = s >= 4'h3 && s <= 4'hA;
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_dir_ones:
		assert property (rd && ix == 4'h1 |=> wb_dat_o == 32'hFF)
		else $error("first dir read not FF");
	a_dir2_ones:
		assert property (rd && ix == 4'h4 |=> wb_dat_o == 32'hFF)
		else $error("second dir read not FF");
	a_dir_sets_oe:
		assert property (wr && ix == 4'h1 && !hi && !lo
			|-> ##2 p1_pin_oe_o == $past(wb_dat_i[7:0], 2))
		else $error("first oe not dir");
	a_dir2_sets_oe:
		assert property (wr && ix == 4'h4
			|-> ##2 p2_pin_oe_o == $past(wb_dat_i[7:0], 2))
		else $error("second oe not dir");
	a_pull_not_out:
		assert property ((p1_pullup_o & p1_pin_oe_o) == 8'h00)
		else $error("pull-up on driven pin");
	a_seg_upper:
		assert property (hi [*2] |=> p1_pin_oe_o[7:4] == 4'hF
			&& p1_pin_o[7:4] == $past(lcd_segment_output_i[7:4]))
		else $error("upper segment drive");
	a_seg_lower:
		assert property (lo [*2] |=> p1_pin_oe_o[3:0] == 4'hF
			&& p1_pin_o[3:0] == $past(lcd_segment_output_i[3:0]))
		else $error("lower segment drive");
	a_reset_quiet:
		assert property ($fell(rst_i)
			|-> (p1_pin_oe_o | p1_pullup_o | p2_pin_oe_o) == 8'h00)
		else $error("pins active after reset");
	c_seg: cover property (hi && lo);
	c_pull: cover property (p1_pullup_o != 8'h00);
	c_rd: cover property (rd);
endmodule
bind lsgp_top lsgp_checker i_lsgp_checker (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .segment_select_field_i, .lcd_segment_output_i, .p1_pin_o,
	.p1_pin_oe_o, .p1_pullup_o, .p2_pin_oe_o);
`default_nettype wire

// File: bench/lsgp_pins.sv
// External pin model: outside drivers and loads of one port
`timescale 1ns/100ps
`default_nettype none
module lsgp_pins (
	// From the block and the bench
	input wire logic [7:0] dat_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] pu_i,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_i,
	// Pin level
	output logic [7:0] pin_o
);
	// A floating pin without pull-up shows the inverse of the block's data
	// so a stale value never passes for a real level
	assign pin_o = oe_i & dat_i
		| ~oe_i & (ext_en_i & ext_i | ~ext_en_i & (pu_i | ~dat_i));
endmodule
`default_nettype wire

// File: bench/lsgp_top_tb.sv
// Testbench: register and pin behaviour of the shared GPIO ports
`timescale 1ns/100ps
`default_nettype none
module lsgp_top_tb;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [3:0] ssf = 4'h0;
	logic [7:0] lcd = 8'h00, e1 = 8'h3C, en1 = 8'hFF, m;
	logic [7:0] pin1, pin2, po1, oe1, pu1, po2, oe2;
	int err_total = 0, total_checks = 0;
	always #5 clk_i = ~clk_i;
	lsgp_top i_lsgp_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .segment_select_field_i(ssf),
		.lcd_segment_output_i(lcd), .p1_pin_i(pin1), .p1_pin_o(po1),
		.p1_pin_oe_o(oe1), .p1_pullup_o(pu1), .p2_pin_i(pin2),
		.p2_pin_o(po2), .p2_pin_oe_o(oe2));
	lsgp_pins i_pins_a (.dat_i(po1), .oe_i(oe1), .pu_i(pu1),
		.ext_en_i(en1), .ext_i(e1), .pin_o(pin1));
	lsgp_pins i_pins_b (.dat_i(po2), .oe_i(oe2), .pu_i(8'h00),
		.ext_en_i(8'hFF), .ext_i(8'hC3), .pin_o(pin2));
	////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// One classic cycle; entered just after a rising edge
	task automatic wb(input logic w, input logic [3:0] ix, input logic [7:0] d);
		int n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		wdat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
		begin
			err_total++;
			close_out;
		end
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [3:0] ix, input logic [7:0] exp);
		wb(1'b0, ix, 8'h00);
		cmp(rdat[7:0], exp);
		cmp(rdat[31:24] | rdat[23:16] | rdat[15:8], 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		cmp(oe1 | pu1 | oe2, 8'h00);
		rdc(4'h0, 8'h3C);
		rdc(4'h1, 8'hFF);
		rdc(4'h2, 8'h00);
		rdc(4'h3, 8'hC3);
		rdc(4'h4, 8'hFF);
		rdc(4'h5, 8'h00);
		$display("test reset done");
		wb(1'b1, 4'h1, 8'hFF);
		rdc(4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'hA5);
		wb(1'b1, 4'h1, 8'hF0);
		// Released pins need an edge for the enable, two for the synchroniser
		repeat (2) @(posedge clk_i);
		rdc(4'h0, 8'hAC);
		cmp(oe1, 8'hF0);
		cmp(po1 & 8'hF0, 8'hA0);
		$display("test direction done");
		en1 <= 8'h00;
		wb(1'b1, 4'h2, 8'hFF);
		cmp(pu1, 8'h0F);
		repeat (3) @(posedge clk_i);
		rdc(4'h0, 8'hAF);
		rdc(4'h2, 8'hFF);
		$display("test pull-up done");
		for (int s = 0; s < 16; s++)
		begin
			ssf <= s[3:0];
			lcd <= {s[3:0], ~s[3:0]};
			repeat (3) @(posedge clk_i);
			m = {(s > 3 && s < 12) ? 4'hF : 4'h0, (s > 2 && s < 11) ? 4'hF : 4'h0};
			cmp(oe1, m | 8'hF0);
			cmp(pu1, ~m & 8'h0F);
			cmp(po1 & (m | 8'hF0), lcd & m | 8'hA0 & ~m);
		end
		ssf <= 4'h0;
		$display("test segment done");
		wb(1'b1, 4'h4, 8'h0F);
		wb(1'b1, 4'h3, 8'h96);
		rdc(4'h3, 8'hC6);
		cmp(oe2, 8'h0F);
		cmp(po2 & 8'h0F, 8'h06);
		$display("test second port done");
		close_out;
	end
endmodule
`default_nettype wire
